// *** rtl/qdsi_pkg.sv ***
// constants, field layout and register map of the quad converter serial write port
// assumes a single pclk domain; the serial pins are sampled, never used as clocks
package qdsi_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
  // word fields
  localparam int CH_HI = 15;
  localparam int CH_LO = 14;
  localparam int MODE_HI = 13;
  localparam int MODE_LO = 12;
  localparam int PD_HI = 11;
  localparam int PD_LO = 10;
  localparam int DATA_HI = 9;
  localparam int DATA_LO = 0;
  // mode field codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_ALL = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  // power-down terminations; active means outputs driven normally
  localparam logic [1:0] PD_ACTIVE = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ = 2'h3;
  // apb register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_LAST_WORD = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CHAN_A = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CHAN_B = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_CHAN_C = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_CHAN_D = 12'h01C;
  // ctrl bit 0: link enable
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // status bits
  localparam int ST_ABORT_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_PD_LO = 2;
  localparam int ST_CNT_LO = 8;
  localparam int FRAME_CNT_W = 8;
  typedef enum logic [1:0] {QDSI_IDLE, QDSI_SHIFT, QDSI_DONE} qdsi_state_t;
endpackage : qdsi_pkg

// *** rtl/qdsi_chan_bank.sv ***
// four channel code registers with registered outputs
// assumes write enables and code come from logic on the same clock
`timescale 1ns/1ps
module qdsi_chan_bank
  import qdsi_pkg::*;
#(
  parameter int CW = CODE_W,
  parameter int NCH = NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NCH-1:0] wr_en,
  input wire logic [CW-1:0] wr_code,
  output logic [NCH-1:0][CW-1:0] codes
);
  logic [NCH-1:0][CW-1:0] codes_r;
  logic [NCH-1:0][CW-1:0] codes_nxt;

  // each enabled channel takes the new code, others hold
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      codes_nxt[i] = wr_en[i] ? wr_code : codes_r[i];
    end
  end

  // outputs start at zero code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      codes_r <= '0;
    end else begin
      codes_r <= codes_nxt;
    end
  end

  assign codes = codes_r;
endmodule : qdsi_chan_bank

// *** rtl/qdsi_top.sv ***
// serial write port and update control of a quad 10-bit converter, with apb status and control
// assumes sclk, sync_n and din are asynchronous pins much slower than pclk (at least 4 pclk per half sclk)
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module qdsi_top
  import qdsi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic [CODE_W-1:0] channel_a_output,
  output logic [CODE_W-1:0] channel_b_output,
  output logic [CODE_W-1:0] channel_c_output,
  output logic [CODE_W-1:0] channel_d_output,
  output logic [1:0] pd_mode,
  output logic update_pulse
);
  // pin synchronisers: stage 1 feeds stage 2 only
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic sclk_s3_r;
  logic sclk_s2;
  logic sync_n_s2;
  logic din_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 3'h3;
      pin_s2_r <= 3'h3;
      sclk_s3_r <= 1'b1; // idle level, so no false edge follows reset
    end else begin
      pin_s1_r <= {din, sync_n, sclk};
      pin_s2_r <= pin_s1_r;
      sclk_s3_r <= pin_s2_r[0];
    end
  end

  assign sclk_s2 = pin_s2_r[0];
  assign sync_n_s2 = pin_s2_r[1];
  assign din_s2 = pin_s2_r[2];

  logic sclk_fall;
  logic frame_low;
  assign sclk_fall = sclk_s3_r & ~sclk_s2;
  assign frame_low = ~sync_n_s2;

  // channel index to one-hot enable
  function automatic logic [NUM_CH-1:0] ch_onehot(input logic [1:0] ch);
    logic [NUM_CH-1:0] oh;
    oh = '0;
    oh[ch] = 1'b1;
    return oh;
  endfunction : ch_onehot

  // frame state
  qdsi_state_t state_r;
  qdsi_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [WORD_W-1:0] shreg_r;
  logic [WORD_W-1:0] shreg_nxt;
  logic [WORD_W-1:0] last_word_r;
  logic [WORD_W-1:0] last_word_nxt;
  logic [1:0] pd_r;
  logic [1:0] pd_nxt;
  logic upd_r;
  logic upd_nxt;
  logic abort_ev;
  logic apply_ev;
  logic [WORD_W-1:0] word_in;
  logic [NUM_CH-1:0] ch_wr;
  logic [CODE_W-1:0] ch_code;
  logic link_en;

  // full word as it stands after the current bit, msb first
  assign word_in = {shreg_r[WORD_W-2:0], din_s2};

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    abort_ev = 1'b0;
    apply_ev = 1'b0;
    unique case (state_r)
      QDSI_IDLE: begin
        // clock activity with select high never reaches the shifter
        if (frame_low && link_en) begin
          state_nxt = QDSI_SHIFT;
          cnt_nxt = '0;
        end
      end
      QDSI_SHIFT: begin
        if (!frame_low) begin
          abort_ev = 1'b1;
          state_nxt = QDSI_IDLE;
        end else if (sclk_fall) begin
          shreg_nxt = word_in;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == LAST_BIT) begin
            apply_ev = 1'b1;
            state_nxt = QDSI_DONE;
          end
        end
      end
      QDSI_DONE: begin
        // extra clocks after the sixteenth are ignored until select rises
        if (!frame_low) begin
          state_nxt = QDSI_IDLE;
        end
      end
      default: begin
        state_nxt = QDSI_IDLE; // unused code falls back to idle
      end
    endcase
  end

  // decode of a completed word
  always_comb begin
    ch_wr = '0;
    ch_code = word_in[DATA_HI:DATA_LO];
    pd_nxt = pd_r;
    last_word_nxt = last_word_r;
    upd_nxt = 1'b0;
    if (apply_ev) begin
      last_word_nxt = word_in;
      unique case (word_in[MODE_HI:MODE_LO])
        MODE_SINGLE: begin
          ch_wr = ch_onehot(word_in[CH_HI:CH_LO]);
          pd_nxt = PD_ACTIVE;
          upd_nxt = 1'b1;
        end
        MODE_ALL: begin
          ch_wr = '1;
          pd_nxt = PD_ACTIVE;
          upd_nxt = 1'b1;
        end
        MODE_PDOWN: begin
          // codes kept so waking restores the earlier codes of channels not written
          pd_nxt = (word_in[PD_HI:PD_LO] == PD_ACTIVE) ? PD_HIZ : word_in[PD_HI:PD_LO];
          upd_nxt = 1'b1;
        end
        MODE_RSVD: begin
          upd_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= QDSI_IDLE;
      cnt_r <= '0;
      shreg_r <= '0;
      last_word_r <= '0;
      pd_r <= PD_ACTIVE;
      upd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      last_word_r <= last_word_nxt;
      pd_r <= pd_nxt;
      upd_r <= upd_nxt;
    end
  end

  logic [NUM_CH-1:0][CODE_W-1:0] codes;

  // codes change only on an applied word, so an abort leaves them intact
  qdsi_chan_bank #(
    .CW(CODE_W),
    .NCH(NUM_CH)
  ) u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ch_wr),
    .wr_code(ch_code),
    .codes(codes)
  );

  assign channel_a_output = codes[0];
  assign channel_b_output = codes[1];
  assign channel_c_output = codes[2];
  assign channel_d_output = codes[3];
  assign pd_mode = pd_r;
  assign update_pulse = upd_r;

  // apb slave: zero wait, read data latched in the setup cycle
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic abort_r;
  logic abort_nxt;
  logic [FRAME_CNT_W-1:0] frames_r;
  logic [FRAME_CNT_W-1:0] frames_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic wr_acc;
  logic setup;
  logic [31:0] status_w;

  assign wr_acc = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign link_en = ctrl_r[CTRL_EN_BIT];

  always_comb begin
    status_w = '0;
    status_w[ST_ABORT_BIT] = abort_r;
    status_w[ST_BUSY_BIT] = (state_r != QDSI_IDLE);
    status_w[ST_PD_LO +: 2] = pd_r;
    status_w[ST_CNT_LO +: FRAME_CNT_W] = frames_r;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    abort_nxt = abort_r;
    frames_nxt = frames_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (wr_acc && paddr == OFS_CTRL) begin
      ctrl_nxt = {31'h0000_0000, pwdata[CTRL_EN_BIT]};
    end
    // write one to clear; a new abort in the same cycle wins
    if (wr_acc && paddr == OFS_STATUS && pwdata[ST_ABORT_BIT]) begin
      abort_nxt = 1'b0;
    end
    if (abort_ev) begin
      abort_nxt = 1'b1;
    end
    if (apply_ev) begin
      frames_nxt = frames_r + 8'h01;
    end
    if (setup) begin
      pslverr_nxt = 1'b0;
      unique case (paddr)
        OFS_CTRL: prdata_nxt = ctrl_r;
        OFS_STATUS: prdata_nxt = status_w;
        OFS_LAST_WORD: prdata_nxt = {16'h0000, last_word_r};
        OFS_CHAN_A: prdata_nxt = {22'h00_0000, codes[0]};
        OFS_CHAN_B: prdata_nxt = {22'h00_0000, codes[1]};
        OFS_CHAN_C: prdata_nxt = {22'h00_0000, codes[2]};
        OFS_CHAN_D: prdata_nxt = {22'h00_0000, codes[3]};
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      abort_r <= 1'b0;
      frames_r <= '0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      abort_r <= abort_nxt;
      frames_r <= frames_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r & psel & penable;
endmodule : qdsi_top

// *** sim/qdsi_host.sv ***
// host-side model of the three-wire serial link
// assumes pclk from the bench; pins change just after a pclk rising edge
`timescale 1ns/1ps
module qdsi_host (
  input wire logic pclk,
  output logic sclk,
  output logic sync_n,
  output logic din
);
  // idle: clock high, frame closed
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // half link period is 4 pclk (100 ns)
  task automatic hw(input int n);
    repeat (n) @(posedge pclk);
  endtask : hw
  // n bits of w msb first; n below 16 closes the frame early
  task automatic send(input logic [15:0] w, input int n);
    sync_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      hw(4);
      din <= w[i];
      sclk <= 1'b1;
      hw(4);
      sclk <= 1'b0;
    end
    hw(4);
    sclk <= 1'b1;
    din <= ~din; // released line shows no stale bit
    hw(4);
    sync_n <= 1'b1;
    hw(8);
  endtask : send
  // clock and data wiggle with the frame closed
  task automatic noise();
    repeat (8) begin
      hw(4);
      sclk <= ~sclk;
      din <= ~din;
    end
  endtask : noise
endmodule : qdsi_host

// *** sim/qdsi_checker.sv ***
// concurrent checks of the channel outputs against the serial pins
// assumes the serial pins change only just after pclk rising edges
`timescale 1ns/1ps
module qdsi_checker
  import qdsi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic [CODE_W-1:0] channel_a_output,
  input wire logic [CODE_W-1:0] channel_b_output,
  input wire logic [CODE_W-1:0] channel_c_output,
  input wire logic [CODE_W-1:0] channel_d_output,
  input wire logic [1:0] pd_mode,
  input wire logic update_pulse
);
  logic [4*CODE_W-1:0] codes;
  logic sclk_q;
  logic [4:0] fall_cnt;
  assign codes = {channel_d_output, channel_c_output, channel_b_output, channel_a_output};
  // link clock falls in the open frame, counted from the raw pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
      fall_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      fall_cnt <= sync_n ? 5'h00 : fall_cnt + 5'(sclk_q & ~sclk);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_zero: assert property ($rose(presetn) |-> codes == '0 && pd_mode == 2'h0)
    else $error("outputs not zero after reset");
  a_count_sixteen: assert property (update_pulse |-> fall_cnt == 5'h10)
    else $error("update without sixteen clock falls");
  // codes and pulse are registered on the same edge, so both are seen together
  a_change_pulse: assert property ($changed({codes, pd_mode}) |-> update_pulse)
    else $error("outputs changed without update pulse");
  a_pulse_single: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  a_idle_stable: assert property (sync_n [*8] |-> $stable({codes, pd_mode}))
    else $error("outputs changed with frame closed");
  a_abort_keep: assert property ($rose(sync_n) && fall_cnt != 5'h10 |=> $stable({codes, pd_mode}) [*6])
    else $error("short frame changed outputs");
  a_all_same: assert property ($changed(channel_a_output) && $changed(channel_b_output) |->
    channel_a_output == channel_b_output && channel_b_output == channel_c_output
    && channel_c_output == channel_d_output) else $error("joint update gave unequal codes");
  a_pd_codes_kept: assert property ($changed(pd_mode) && pd_mode != 2'h0 |-> $stable(codes))
    else $error("power-down altered codes");
  c_update: cover property (update_pulse);
  c_abort: cover property ($rose(sync_n) && fall_cnt != 5'h10 && fall_cnt != 5'h00);
  c_hiz: cover property (pd_mode == PD_HIZ);
endmodule : qdsi_checker
bind qdsi_top qdsi_checker u_chk (.pclk(pclk), .presetn(presetn), .sclk(sclk), .sync_n(sync_n),
  .channel_a_output(channel_a_output), .channel_b_output(channel_b_output), .channel_c_output(channel_c_output),
  .channel_d_output(channel_d_output), .pd_mode(pd_mode), .update_pulse(update_pulse));

// *** sim/tb.sv ***
// self-checking bench: frames from the host model, apb reads of the channel registers
// assumes the checker binds itself to qdsi_top
`timescale 1ns/1ps
module tb
  import qdsi_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, update_pulse, sclk, sync_n, din, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] pd_mode, exp_pd;
  logic [CODE_W-1:0] ca, cb, cc, cd;
  logic [NUM_CH-1:0][CODE_W-1:0] exp_c, outs;
  int bad_count = 0;
  int check_count = 0;
  assign outs = {cd, cc, cb, ca};
  qdsi_top u_qdsi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .sync_n(sync_n), .din(din), .channel_a_output(ca), .channel_b_output(cb), .channel_c_output(cc),
    .channel_d_output(cd), .pd_mode(pd_mode), .update_pulse(update_pulse));
  qdsi_host u_host (.pclk(pclk), .sclk(sclk), .sync_n(sync_n), .din(din));
  // 25 ns clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge; idle edge after it
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmp_out();
    for (int i = 0; i < NUM_CH; i++) chk("channel output", 32'(exp_c[i]), 32'(outs[i]));
    chk("termination", 32'(exp_pd), 32'(pd_mode));
  endtask : cmp_out
  task automatic t_reset();
    exp_c = '0;
    exp_pd = PD_ACTIVE;
    cmp_out();
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(err));
  endtask : t_reset
  // each channel alone, codes 3FF, 07F, 00F and 001
  task automatic t_single();
    logic [CODE_W-1:0] v;
    for (int i = 0; i < NUM_CH; i++) begin
      v = 10'h3FF >> (3 * i);
      u_host.send({2'(i), MODE_SINGLE, PD_ACTIVE, v}, 16);
      exp_c[i] = v;
      cmp_out();
      apb(1'b0, OFS_CHAN_A + ADDR_W'(4 * i), 32'h0);
      chk("code register", 32'(v), rd);
    end
  endtask : t_single
  task automatic t_all();
    u_host.send({2'h2, MODE_ALL, PD_ACTIVE, 10'h2AA}, 16);
    exp_c = {NUM_CH{10'h2AA}};
    cmp_out();
  endtask : t_all
  // frame closed one bit short, then abort flag cleared
  task automatic t_abort();
    u_host.send({2'h1, MODE_ALL, PD_ACTIVE, 10'h000}, 15);
    cmp_out();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("abort flag", 32'h1, 32'(rd[ST_ABORT_BIT]));
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("abort flag", 32'h0, 32'(rd[ST_ABORT_BIT]));
  endtask : t_abort
  // every termination option; option 0 reads as hi-z
  task automatic t_pdown();
    for (int o = 0; o < 4; o++) begin
      u_host.send({2'h0, MODE_PDOWN, 2'(o), 10'h123}, 16);
      exp_pd = (o == 0) ? PD_HIZ : 2'(o);
      cmp_out();
    end
    u_host.send({2'h3, MODE_SINGLE, PD_ACTIVE, 10'h0C3}, 16);
    exp_c[3] = 10'h0C3;
    exp_pd = PD_ACTIVE;
    cmp_out();
  endtask : t_pdown
  // clock activity outside a frame, a frame with the link off, then a reserved mode word
  task automatic t_ignored();
    u_host.noise();
    cmp_out();
    apb(1'b1, OFS_CTRL, 32'h0);
    u_host.send({2'h1, MODE_ALL, PD_ACTIVE, 10'h155}, 16);
    cmp_out();
    apb(1'b1, OFS_CTRL, CTRL_RST);
    u_host.send({2'h0, MODE_RSVD, PD_1K, 10'h3FF}, 16);
    cmp_out();
    apb(1'b0, OFS_LAST_WORD, 32'h0);
    chk("last word", {16'h0000, 2'h0, MODE_RSVD, PD_1K, 10'h3FF}, rd);
    // eleven complete frames so far: five single, one joint, four power-down, one reserved
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("frame count", 32'h0000_000B, 32'(rd[ST_CNT_LO +: FRAME_CNT_W]));
  endtask : t_ignored
  // reset in mid-run returns outputs and status to zero until the next full frame
  task automatic t_rereset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_c = '0;
    exp_pd = PD_ACTIVE;
    cmp_out();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status after reset", 32'h0, rd);
    u_host.send({2'h1, MODE_SINGLE, PD_ACTIVE, 10'h2C5}, 16);
    exp_c[1] = 10'h2C5;
    cmp_out();
  endtask : t_rereset
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // watchdog: a few thousand cycles expected
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_all();
    t_abort();
    t_pdown();
    t_ignored();
    t_rereset();
    end_of_test();
  end
endmodule : tb
